/* design/pin_share_pkg.sv */
// Purpose : Shared constants and carrier types for the port 4 / port 5 pin sharing block
// Assumes : APB slave with 32-bit data, one register per aligned word
// Notes   : Pin indices of port 4 follow the shared peripheral assignment
package pin_share_pkg;

  // Register byte offsets
  localparam logic [7:0] PORT4_DATA_OFS   = 8'h00;  // Port 4 output data
  localparam logic [7:0] PORT4_DIR_OFS    = 8'h04;  // Port 4 direction, 1 = output
  localparam logic [7:0] PORT4_PULLUP_OFS = 8'h08;  // Port 4 pull-up select
  localparam logic [7:0] PORT5_DATA_OFS   = 8'h0C;  // Port 5 output data
  localparam logic [7:0] PORT5_DIR_OFS    = 8'h10;  // Port 5 direction, 1 = output
  localparam logic [7:0] PIN_LEVEL_OFS    = 8'h14;  // Read only: pin levels
  localparam logic [7:0] PIN_STATUS_OFS   = 8'h18;  // Read only: override and contention

  // Reset values
  localparam logic [7:0] PORT4_DATA_RST   = 8'h00;
  localparam logic [7:0] PORT4_DIR_RST    = 8'h00;
  localparam logic [7:0] PORT4_PULLUP_RST = 8'h00;
  localparam logic [1:0] PORT5_DATA_RST   = 2'h0;
  localparam logic [1:0] PORT5_DIR_RST    = 2'h0;

  // Port 4 and port 5 pin positions
  localparam int WAVE_A_PIN   = 0;  // port4_pin0
  localparam int WAVE_B_PIN   = 1;  // port4_pin1
  localparam int UART_RX_PIN  = 2;  // port4_pin2
  localparam int UART_TX_PIN  = 3;  // port4_pin3
  localparam int UART_CLK_PIN = 4;  // port4_pin4
  localparam int XS1_RX_PIN   = 5;  // port4_pin5
  localparam int XS1_TX_PIN   = 6;  // port4_pin6
  localparam int XS1_CLK_PIN  = 7;  // port4_pin7
  localparam int XS2_RX_PIN   = 0;  // port5_pin0

  // Status register field positions
  localparam int STAT_UART_CONT = 8;  // Receive pin driven during UART reception
  localparam int STAT_XS1_CONT  = 9;  // Receive pin driven during serial 1 input
  localparam int STAT_XS2_CONT  = 10; // Receive pin driven during serial 2 input

  // Peripheral outputs and their enables toward the pins
  typedef struct packed {
    logic wave_a;        // pulse_timer1_wave_a
    logic wave_a_en;
    logic wave_b;        // pulse_timer1_wave_b
    logic wave_b_en;
    logic uart_tx;       // uart_tx_out
    logic uart_tx_en;
    logic uart_clk;      // uart_serial_clk, output side
    logic uart_clk_en;
    logic xs1_tx;        // xserial1_tx_out
    logic xs1_tx_en;
    logic xs1_clk;       // xserial1_serial_clk, output side
    logic xs1_clk_en;
  } periph_out_type;

  // Pin levels delivered to the peripherals
  typedef struct packed {
    logic uart_rx_in;          // uart_rx_in
    logic uart_clk_in;         // uart_serial_clk, input side
    logic xserial1_rx_in;      // xserial1_rx_in
    logic xserial1_clk_in;     // xserial1_serial_clk, input side
    logic xserial2_rx_in;      // xserial2_rx_in
    logic updown_cnt1_clk_a;   // updown_cnt1_clk_a
  } periph_in_type;

  // Reception activity flags from the serial peripherals
  typedef struct packed {
    logic uart_rx_busy;
    logic xs1_rx_busy;
    logic xs2_rx_busy;
  } rx_busy_type;

endpackage : pin_share_pkg

/* design/pin_share.sv */
// Purpose : Pin sharing for port 4 and port 5 pins 0-1 with timer, UART and serial peripherals
// Assumes : Single clock core_clk at 20 MHz, synchronous active-high reset srst
// Notes   : Pin outputs, enables and peripheral inputs are registered, one cycle of delay
//
// Notes on behaviour
// - Pull-up acts only while pin is input
// - Pins 0-1 are port only without waveform
// - Enabled timer waveform replaces port data
// - UART transmit drives pin only when enabled
// - UART clock driven only when output enabled
// - UART receive input sampled continuously from pin
// - Serial 1 data drives pin only when enabled
// - Serial 1 clock driven only when enabled
// - Serial 1/2 data inputs sampled continuously
// - Serial 2 input pin also feeds counter
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module pin_share
  import pin_share_pkg::*;
(
  input  wire logic           core_clk,          // 20 MHz clock
  input  wire logic           srst,              // Synchronous reset
  input  wire logic           psel,              // APB select
  input  wire logic           penable,           // APB access phase
  input  wire logic           pwrite,            // APB direction
  input  wire logic [7:0]     paddr,             // APB byte address
  input  wire logic [31:0]    pwdata,            // APB write data
  output logic      [31:0]    prdata,            // APB read data
  output logic                pready,            // APB ready
  output logic                pslverr,           // APB error on unmapped address
  input  wire periph_out_type periph_out,        // Peripheral outputs with enables
  input  wire rx_busy_type    rx_busy,           // Peripheral reception activity
  output periph_in_type       periph_in,         // Pin levels to the peripherals
  input  wire logic [7:0]     port4_pin_in,      // Port 4 pin levels
  output logic      [7:0]     port4_pin_out,     // Port 4 pin drive value
  output logic      [7:0]     port4_pin_oe,      // Port 4 pin drive enable
  output logic      [7:0]     port4_pullup_en,   // Port 4 pull-up resistor enable
  input  wire logic [1:0]     port5_pin_in,      // Port 5 pin levels
  output logic      [1:0]     port5_pin_out,     // Port 5 pin drive value
  output logic      [1:0]     port5_pin_oe       // Port 5 pin drive enable
);

  logic [7:0]  port4_data_q;          // Port 4 output data
  logic [7:0]  port4_dir_q;           // Port 4 direction
  logic [7:0]  port4_pullup_select_q; // Port 4 pull-up select
  logic [1:0]  port5_data_q;          // Port 5 output data
  logic [1:0]  port5_dir_q;           // Port 5 direction
  logic [7:0]  ovr_en;                // Peripheral owns the pin
  logic [7:0]  ovr_val;               // Peripheral drive value
  logic [7:0]  p4_oe_d;               // Next port 4 drive enable
  logic [7:0]  p4_out_d;              // Next port 4 drive value
  logic [2:0]  cont_d;                // Receive pins driven during reception
  logic        wr_en;                 // Write commits this edge
  logic        rd_en;                 // Read data is loaded this edge
  logic        addr_ok;               // Address is mapped
  logic [31:0] rdata_d;               // Read data mux

  // Peripheral ownership of each port 4 pin; receive pins are never owned
  always_comb begin
    ovr_en  = 8'h00;
    ovr_val = 8'h00;
    ovr_en[WAVE_A_PIN]    = periph_out.wave_a_en;
    ovr_val[WAVE_A_PIN]   = periph_out.wave_a;
    ovr_en[WAVE_B_PIN]    = periph_out.wave_b_en;
    ovr_val[WAVE_B_PIN]   = periph_out.wave_b;
    ovr_en[UART_TX_PIN]   = periph_out.uart_tx_en;
    ovr_val[UART_TX_PIN]  = periph_out.uart_tx;
    ovr_en[UART_CLK_PIN]  = periph_out.uart_clk_en;
    ovr_val[UART_CLK_PIN] = periph_out.uart_clk;
    ovr_en[XS1_TX_PIN]    = periph_out.xs1_tx_en;
    ovr_val[XS1_TX_PIN]   = periph_out.xs1_tx;
    ovr_en[XS1_CLK_PIN]   = periph_out.xs1_clk_en;
    ovr_val[XS1_CLK_PIN]  = periph_out.xs1_clk;
  end

  // Per-pin selection between peripheral and port registers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // Enabled peripheral forces output and its own value
      assign p4_oe_d[gi]  = ovr_en[gi] | port4_dir_q[gi];
      assign p4_out_d[gi] = ovr_en[gi] ? ovr_val[gi] : port4_data_q[gi];

      // Pin drive, enable and pull-up registers
      always_ff @(posedge core_clk) begin
        if (srst) begin
          port4_pin_out[gi]   <= 1'b0;
          port4_pin_oe[gi]    <= 1'b0;
          port4_pullup_en[gi] <= 1'b0;
        end else begin
          port4_pin_out[gi]   <= p4_out_d[gi];
          port4_pin_oe[gi]    <= p4_oe_d[gi];
          port4_pullup_en[gi] <= port4_pullup_select_q[gi] & ~p4_oe_d[gi];
        end
      end
    end
  endgenerate

  // Port 5 pins are plain port pins on the output side
  always_ff @(posedge core_clk) begin
    if (srst) begin
      port5_pin_out <= 2'h0;
      port5_pin_oe  <= 2'h0;
    end else begin
      port5_pin_out <= port5_data_q;
      port5_pin_oe  <= port5_dir_q;
    end
  end

  // Pin levels always pass to the peripheral inputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      periph_in <= '0;
    end else begin
      periph_in.uart_rx_in        <= port4_pin_in[UART_RX_PIN];
      periph_in.uart_clk_in       <= port4_pin_in[UART_CLK_PIN];
      periph_in.xserial1_rx_in    <= port4_pin_in[XS1_RX_PIN];
      periph_in.xserial1_clk_in   <= port4_pin_in[XS1_CLK_PIN];
      periph_in.xserial2_rx_in    <= port5_pin_in[XS2_RX_PIN];
      periph_in.updown_cnt1_clk_a <= port5_pin_in[XS2_RX_PIN];
    end
  end

  // Receive pins that the port drives while reception runs
  assign cont_d[0] = rx_busy.uart_rx_busy & port4_pin_oe[UART_RX_PIN];
  assign cont_d[1] = rx_busy.xs1_rx_busy & port4_pin_oe[XS1_RX_PIN];
  assign cont_d[2] = rx_busy.xs2_rx_busy & port5_pin_oe[XS2_RX_PIN];

  // APB handshake: ready rises in the second access cycle
  assign wr_en   = psel & penable & pready & pwrite;
  assign rd_en   = psel & penable & ~pready & ~pwrite;
  assign addr_ok = (paddr <= PIN_STATUS_OFS) && (paddr[1:0] == 2'b00);

  // Ready and error flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (paddr == PORT4_DATA_OFS) begin
      rdata_d[7:0] = port4_data_q;
    end else if (paddr == PORT4_DIR_OFS) begin
      rdata_d[7:0] = port4_dir_q;
    end else if (paddr == PORT4_PULLUP_OFS) begin
      rdata_d[7:0] = port4_pullup_select_q;
    end else if (paddr == PORT5_DATA_OFS) begin
      rdata_d[1:0] = port5_data_q;
    end else if (paddr == PORT5_DIR_OFS) begin
      rdata_d[1:0] = port5_dir_q;
    end else if (paddr == PIN_LEVEL_OFS) begin
      rdata_d[9:0] = {port5_pin_in, port4_pin_in};
    end else if (paddr == PIN_STATUS_OFS) begin
      rdata_d[7:0] = ovr_en;
      rdata_d[STAT_XS2_CONT:STAT_UART_CONT] = cont_d;
    end
  end

  // Read data register, loaded in the first access cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rdata_d;
    end
  end

  // Port configuration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      port4_data_q          <= PORT4_DATA_RST;
      port4_dir_q           <= PORT4_DIR_RST;
      port4_pullup_select_q <= PORT4_PULLUP_RST;
      port5_data_q          <= PORT5_DATA_RST;
      port5_dir_q           <= PORT5_DIR_RST;
    end else if (wr_en) begin
      if (paddr == PORT4_DATA_OFS) begin
        port4_data_q <= pwdata[7:0];
      end else if (paddr == PORT4_DIR_OFS) begin
        port4_dir_q <= pwdata[7:0];
      end else if (paddr == PORT4_PULLUP_OFS) begin
        port4_pullup_select_q <= pwdata[7:0];
      end else if (paddr == PORT5_DATA_OFS) begin
        port5_data_q <= pwdata[1:0];
      end else if (paddr == PORT5_DIR_OFS) begin
        port5_dir_q <= pwdata[1:0];
      end
    end
  end

  // Checks on the pin selection and the APB handshake
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Pull-up never active on a driven pin
  property p_pullup_input_only;
    (port4_pullup_en & port4_pin_oe) == 8'h00;
  endproperty
  a_pullup_input_only: assert property (p_pullup_input_only)
    else $error("Pull-up active on a driven pin");

  // Waveform disabled for two cycles leaves the pin to the port
  sequence s_wave_off;
    !periph_out.wave_a_en [*2];
  endsequence
  property p_port_when_wave_off;
    s_wave_off |-> port4_pin_out[0] == $past(port4_data_q[0])
                   && port4_pin_oe[0] == $past(port4_dir_q[0]);
  endproperty
  a_port_when_wave_off: assert property (p_port_when_wave_off)
    else $error("Pin 0 not under port control with waveform off");

  // Enabled waveform appears one cycle later on its pin
  property p_wave_drive;
    periph_out.wave_b_en |=> port4_pin_oe[1] && port4_pin_out[1] == $past(periph_out.wave_b);
  endproperty
  a_wave_drive: assert property (p_wave_drive)
    else $error("Waveform not driven on pin 1");

  // UART transmit follows its enable
  property p_uart_tx;
    periph_out.uart_tx_en |=> port4_pin_oe[3] && port4_pin_out[3] == $past(periph_out.uart_tx);
  endproperty
  a_uart_tx: assert property (p_uart_tx)
    else $error("UART transmit not driven");

  // UART clock pin is input when neither clock output nor port output
  property p_uart_clk_in;
    !periph_out.uart_clk_en && !port4_dir_q[4] |=> !port4_pin_oe[4];
  endproperty
  a_uart_clk_in: assert property (p_uart_clk_in)
    else $error("UART clock pin driven while disabled");

  // UART receive level reaches the peripheral one cycle later
  // The first cycle after reset still shows the cleared copy, so it is skipped
  property p_uart_rx;
    !$past(srst) |-> periph_in.uart_rx_in == $past(port4_pin_in[UART_RX_PIN]);
  endproperty
  a_uart_rx: assert property (p_uart_rx)
    else $error("UART receive input not following pin");

  // Serial 1 data output follows its enable
  property p_xs1_tx;
    periph_out.xs1_tx_en |=> port4_pin_oe[6] && port4_pin_out[6] == $past(periph_out.xs1_tx);
  endproperty
  a_xs1_tx: assert property (p_xs1_tx)
    else $error("Serial 1 data not driven");

  // Serial 1 clock follows its enable
  property p_xs1_clk;
    periph_out.xs1_clk_en |=> port4_pin_oe[7] && port4_pin_out[7] == $past(periph_out.xs1_clk);
  endproperty
  a_xs1_clk: assert property (p_xs1_clk)
    else $error("Serial 1 clock not driven");

  // Serial data inputs track their pins
  property p_serial_rx;
    !$past(srst) |-> periph_in.xserial1_rx_in == $past(port4_pin_in[XS1_RX_PIN])
                     && periph_in.xserial2_rx_in == $past(port5_pin_in[XS2_RX_PIN]);
  endproperty
  a_serial_rx: assert property (p_serial_rx)
    else $error("Serial data input not following pin");

  // Counter clock A and serial 2 input share one source
  property p_cnt_clk_a;
    periph_in.updown_cnt1_clk_a == periph_in.xserial2_rx_in;
  endproperty
  a_cnt_clk_a: assert property (p_cnt_clk_a)
    else $error("Counter clock A differs from serial 2 input");

  // Without any peripheral enable, port 4 pins follow the registers
  property p_port_default;
    ovr_en == 8'h00 |=> port4_pin_oe == $past(port4_dir_q)
                        && port4_pin_out == $past(port4_data_q);
  endproperty
  a_port_default: assert property (p_port_default)
    else $error("Port registers not controlling pins");

  // UART receive pin is driven only through its port direction
  property p_uart_rx_pin_free;
    !port4_dir_q[UART_RX_PIN] |=> !port4_pin_oe[UART_RX_PIN];
  endproperty
  a_uart_rx_pin_free: assert property (p_uart_rx_pin_free)
    else $error("UART receive pin driven without port direction");

  // Serial 1 receive pin is driven only through its port direction
  property p_xs1_rx_pin_free;
    !port4_dir_q[XS1_RX_PIN] |=> !port4_pin_oe[XS1_RX_PIN];
  endproperty
  a_xs1_rx_pin_free: assert property (p_xs1_rx_pin_free)
    else $error("Serial 1 receive pin driven without port direction");

  // Port 5 pins follow their registers one cycle later
  property p_port5_follow;
    ##1 port5_pin_oe == $past(port5_dir_q) && port5_pin_out == $past(port5_data_q);
  endproperty
  a_port5_follow: assert property (p_port5_follow)
    else $error("Port 5 pins not following their registers");

  // Ready stands for one cycle only
  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("Ready held for more than one cycle");

  // Error flag only alongside ready
  property p_slverr_with_ready;
    pslverr |-> pready;
  endproperty
  a_slverr_with_ready: assert property (p_slverr_with_ready)
    else $error("Error flag raised without ready");

endmodule : pin_share

/* dv/board_model.sv */
// Purpose : Board-side model of the shared port 4 and port 5 pins
// Assumes : Index 9:8 are port 5 pins 1:0, index 7:0 are port 4 pins
// Notes   : An undriven pin without pull-up flips every cycle, so no stale level passes
`timescale 1ns/10ps
module board_model (
  input  wire logic       core_clk,  // Device clock
  input  wire logic [9:0] dev_out,   // Device drive values
  input  wire logic [9:0] dev_oe,    // Device drive enables
  input  wire logic [9:0] pull_en,   // Pull-up enables
  input  wire logic [9:0] ext_val,   // Board drive values
  input  wire logic [9:0] ext_en,    // Board drive enables, set only by bench command
  output logic      [9:0] pin_lvl    // Resolved pin levels
);
  logic [9:0] last_q = '0;  // Level seen in the previous cycle

  // Resolve each pin; board drives receive pins only when told to
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (dev_oe[i]) pin_lvl[i] = dev_out[i];         // Device drive wins
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];    // Board drive
      else if (pull_en[i]) pin_lvl[i] = 1'b1;         // Pull-up level
      else pin_lvl[i] = ~last_q[i];                   // Floating line
    end
  end

  // Remember the last level for the floating pattern
  always_ff @(posedge core_clk) begin
    last_q <= pin_lvl;
  end
endmodule : board_model

/* dv/tb.sv */
// Purpose : Self-checking bench for the port 4 / port 5 pin sharing block
// Assumes : APB answers with one wait state; pin outputs lag their cause by one cycle
// Notes   : Checks wait three edges after each stimulus change
`timescale 1ns/10ps
module tb;
  import pin_share_pkg::*;
  logic           core_clk, srst, psel, penable, pwrite;  // Clock, reset, APB control
  logic [7:0]     paddr;                                  // APB address
  logic [31:0]    pwdata, prdata, rd;                     // APB data
  logic           pready, pslverr, err;                   // APB answer
  logic [11:0]    pout;                                   // Peripheral outputs, raw
  rx_busy_type    rx_busy;                                // Reception flags
  periph_in_type  periph_in;                              // Levels to peripherals
  logic [7:0]     p4_out, p4_oe, p4_pu;                   // Port 4 pin controls
  logic [1:0]     p5_out, p5_oe;                          // Port 5 pin controls
  logic [9:0]     lvl, ext_val, ext_en;                   // Pin levels, board drive
  int             mismatches, compares, pins[6];          // Counters, channel pin map
  logic [11:0]    pv;                                     // Next peripheral output pattern
  localparam logic [7:0] P4_DAT = 8'hA5;                  // Port 4 data written by the test

  // Clock generator, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  pin_share u_pin_share (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_out(periph_out_type'(pout)), .rx_busy(rx_busy),
    .periph_in(periph_in), .port4_pin_in(lvl[7:0]), .port4_pin_out(p4_out),
    .port4_pin_oe(p4_oe), .port4_pullup_en(p4_pu), .port5_pin_in(lvl[9:8]),
    .port5_pin_out(p5_out), .port5_pin_oe(p5_oe));

  board_model u_board_model (.core_clk(core_clk), .dev_out({p5_out, p4_out}),
    .dev_oe({p5_oe, p4_oe}), .pull_en({2'h0, p4_pu}), .ext_val(ext_val), .ext_en(ext_en),
    .pin_lvl(lvl));

  // Compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One APB transfer: setup, access, hold until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("BAD %0t no ready from the register bus", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Let pin outputs settle
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle

  // Verdict and end of run
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Watchdog against a hung handshake
  initial begin
    #(50 * 5000);
    mismatches++;
    end_sim();
  end

  // Test sequence
  initial begin
    mismatches = 0; compares = 0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pout = 12'h000; rx_busy = '0; ext_val = 10'h000;
    ext_en = 10'h000; pins = '{0, 1, 3, 4, 6, 7};
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a <= 16; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      check(rd, 32'h0, "reset value");
    end
    check({p4_oe, p4_pu, 6'h0, p5_oe}, 32'h0, "reset pins");
    $display("test reset done");
    // Port registers control undriven-by-peripheral pins
    apb(1'b1, PORT4_DATA_OFS, {24'h0, P4_DAT}); apb(1'b1, PORT4_DIR_OFS, 32'hFF);
    apb(1'b1, PORT4_PULLUP_OFS, 32'hFF);
    settle();
    check({p4_oe, p4_out, p4_pu}, 32'hFFA500, "port drive, pull-up off");
    apb(1'b1, PORT4_DIR_OFS, 32'h0F);
    settle();
    check({p4_oe, p4_pu}, 16'h0FF0, "pull-up on inputs only");
    apb(1'b1, PORT4_DIR_OFS, 32'h00);
    apb(1'b0, PORT4_DATA_OFS, 32'h0);
    check(rd, {24'h0, P4_DAT}, "port 4 data readback");
    check({31'h0, err}, 32'h0, "no error on mapped read");
    apb(1'b0, 8'h1C, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped read");
    apb(1'b1, PORT5_DATA_OFS, 32'h2);
    apb(1'b1, PORT5_DIR_OFS, 32'h3);
    apb(1'b0, PORT5_DATA_OFS, 32'h0);
    check(rd, 32'h2, "port 5 readback");
    settle();
    check({p5_oe, p5_out}, 32'hE, "port 5 drive");
    apb(1'b1, PORT5_DIR_OFS, 32'h0);
    settle();
    check({p5_oe, p5_out}, 32'h2, "port 5 released");
    $display("test port done");
    // Each peripheral output overrides port data and direction
    for (int k = 0; k < 6; k++) begin
      for (int v = 0; v < 3; v++) begin
        pv = 12'h000;
        pv[10 - 2 * k] = (v < 2);
        pv[11 - 2 * k] = (v != 0);
        @(posedge core_clk);
        pout <= pv;
        settle();
        check({p4_oe[pins[k]], p4_out[pins[k]], p4_pu[pins[k]]},
              (v < 2) ? {1'b1, v[0], 1'b0} : {1'b0, P4_DAT[pins[k]], 1'b1},
              "peripheral drive");
      end
    end
    @(posedge core_clk);
    pout <= 12'h000;
    $display("test override done");
    // Pin levels reach the peripherals, receive and clock inputs
    ext_en <= 10'h1B4;
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      ext_val <= v[0] ? 10'h3FF : 10'h000;
      settle();
      check({periph_in.uart_rx_in, periph_in.xserial1_rx_in}, {2{v[0]}}, "rx inputs");
      check({periph_in.uart_clk_in, periph_in.xserial1_clk_in}, {2{v[0]}}, "clk in");
      check({periph_in.xserial2_rx_in, periph_in.updown_cnt1_clk_a}, {2{v[0]}}, "p5");
    end
    @(posedge core_clk);
    ext_en <= 10'h000;
    // Port drive on the receive pin during reception shows in status
    rx_busy <= 3'b100;
    apb(1'b1, PORT4_DIR_OFS, 32'h04);
    settle();
    apb(1'b0, PIN_STATUS_OFS, 32'h0);
    check(rd[STAT_UART_CONT], 1'b1, "rx contention");
    $display("test input done");
    end_sim();
  end
endmodule : tb
